// >>> include/acrr_pkg.sv
// constants and carrier types of the conversion result register bank
// assumes an apb master with 32-bit data and word-aligned addresses
//
// Contract
// - only reset class three clears result registers
// - unused bits 31:19 and 15:12 read zero
// - overrun set when unread result is overwritten
// - overrun only in overwrite mode, not software
// - reading result register clears overrun flag
// - fresh set on new result, cleared on read
// - bit 16 selects overwrite or hold-until-read
// - bits 11:0 hold latest accepted channel result
// - 8-bit result in 11:4, low four zero
// - 10-bit result in 11:2, low two zero
package acrr_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] OFS_RESULT_CH3 = 12'h064;
	localparam logic [11:0] OFS_RESULT_CH4 = 12'h060;
	localparam logic [11:0] OFS_IRQ_STATUS = 12'h100;
	localparam logic [11:0] OFS_IRQ_MASK   = 12'h104;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int          POS_OVERRUN    = 18;
	localparam int          POS_FRESH      = 17;
	localparam int          POS_HOLD       = 16;
	localparam int          RESULT_W       = 12;
	localparam logic [11:0] RST_RESULT     = 12'h000;
	localparam logic [1:0]  RST_MASK       = 2'h0;

	// conversion width delivered with a result
	typedef enum logic [1:0] {
		ACRR_RES_8  = 2'b00,
		ACRR_RES_10 = 2'b01
	} acrr_width_type;

	// one result delivered by the converter sequencing logic
	typedef struct packed {
		logic           valid;
		acrr_width_type width;
		logic [9:0]     raw;
	} acrr_sample_type;

endpackage : acrr_pkg

// >>> rtl/acrr_bank.sv
// result holding registers for converter channels three and four
// assumes the sequencer runs on REF_CLK and pulses one result per cycle
// per channel; RESET_CLASS3_B is the heavy reset, RST_B the light one
`timescale 1ns/1ps
module acrr_bank #(
	parameter int NUM_CH = 2
) (
	input  wire logic                      REF_CLK,
	input  wire logic                      RST_B,
	input  wire logic                      RESET_CLASS3_B,
	input  wire logic                      PSEL,
	input  wire logic                      PENABLE,
	input  wire logic                      PWRITE,
	input  wire logic [11:0]               PADDR,
	input  wire logic [31:0]               PWDATA,
	input  wire logic [3:0]                PSTRB,
	output logic      [31:0]               PRDATA,
	output logic                           PREADY,
	output logic                           PSLVERR,
	input  wire acrr_pkg::acrr_sample_type SAMPLE_CH3,
	input  wire acrr_pkg::acrr_sample_type SAMPLE_CH4,
	input  wire logic                      SOFTWARE_MODE,
	output logic                           IRQ
);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (NUM_CH != 2) begin : g_bad_ch
		$error("acrr_bank serves exactly two channels");
	end

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic                        setup;
	logic [NUM_CH-1:0]           hit_ch;
	logic                        hit_sts;
	logic                        hit_msk;
	logic [NUM_CH-1:0]           rd_ch;
	logic [NUM_CH-1:0]           wr_ch;
	logic                        wr_sts;
	logic                        wr_msk;
	acrr_pkg::acrr_sample_type   smp [NUM_CH];
	logic [acrr_pkg::RESULT_W-1:0] sample_value [NUM_CH];
	logic [NUM_CH-1:0]           fresh_flag;
	logic [NUM_CH-1:0]           overwrite_flag;
	logic [NUM_CH-1:0]           hold_until_read;
	logic [NUM_CH-1:0]           take;
	logic [NUM_CH-1:0]           ovr_evt;
	logic [NUM_CH-1:0]           next_fresh;
	logic [NUM_CH-1:0]           next_overwrite;
	logic [2*NUM_CH-1:0]         irq_status;
	logic [2*NUM_CH-1:0]         irq_mask;
	logic [2*NUM_CH-1:0]         irq_evt;
	logic [31:0]                 next_prdata;

	assign smp[0] = SAMPLE_CH3;
	assign smp[1] = SAMPLE_CH4;

	// setup phase only: zero-wait answer, effect at the access edge
	assign setup   = PSEL && !PENABLE;
	assign hit_ch  = {PADDR == acrr_pkg::OFS_RESULT_CH4,
		PADDR == acrr_pkg::OFS_RESULT_CH3};
	assign hit_sts = PADDR == acrr_pkg::OFS_IRQ_STATUS;
	assign hit_msk = PADDR == acrr_pkg::OFS_IRQ_MASK;
	assign rd_ch   = (PSEL && PENABLE && !PWRITE) ? hit_ch : '0;
	assign wr_ch   = (PSEL && PENABLE && PWRITE && PSTRB[2]) ? hit_ch : '0;
	assign wr_sts  = PSEL && PENABLE && PWRITE && PSTRB[0] && hit_sts;
	assign wr_msk  = PSEL && PENABLE && PWRITE && PSTRB[0] && hit_msk;

	// ----------------------------------------------------------------
	// per channel result holding
	// ----------------------------------------------------------------
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		// a pending result blocks the write in hold mode
		assign take[c] = smp[c].valid &&
			!(hold_until_read[c] && fresh_flag[c]);
		assign ovr_evt[c] = take[c] && fresh_flag[c] && !rd_ch[c] &&
			!hold_until_read[c] && !SOFTWARE_MODE;
		// fresh wins over a read in the same cycle
		assign next_fresh[c] = take[c] ? 1'b1 :
			(rd_ch[c] ? 1'b0 : fresh_flag[c]);
		assign next_overwrite[c] = ovr_evt[c] ? 1'b1 :
			(rd_ch[c] ? 1'b0 : overwrite_flag[c]);

		// only the heavy reset class reaches these bits
		always_ff @(posedge REF_CLK or negedge RESET_CLASS3_B) begin
			if (!RESET_CLASS3_B) begin
				sample_value[c]    <= acrr_pkg::RST_RESULT;
				fresh_flag[c]      <= 1'b0;
				overwrite_flag[c]  <= 1'b0;
				hold_until_read[c] <= 1'b0;
			end else begin
				fresh_flag[c]     <= next_fresh[c];
				overwrite_flag[c] <= next_overwrite[c];
				if (wr_ch[c]) begin
					hold_until_read[c] <= PWDATA[acrr_pkg::POS_HOLD];
				end
				if (take[c]) begin
					if (smp[c].width == acrr_pkg::ACRR_RES_8) begin
						sample_value[c] <= {smp[c].raw[7:0], 4'h0};
					end else begin
						sample_value[c] <= {smp[c].raw, 2'h0};
					end
				end
			end
		end

		assign irq_evt[2*c]   = take[c];
		assign irq_evt[2*c+1] = ovr_evt[c];
	end

	// ----------------------------------------------------------------
	// interrupt status and mask
	// ----------------------------------------------------------------
	// status: new result and overrun per channel; a set beats a clear
	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			irq_status <= '0;
		end else begin
			irq_status <= irq_evt |
				(irq_status & ~(wr_sts ? PWDATA[2*NUM_CH-1:0] : '0));
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			irq_mask <= {2{acrr_pkg::RST_MASK}};
		end else if (wr_msk) begin
			irq_mask <= PWDATA[2*NUM_CH-1:0];
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			IRQ <= 1'b0;
		end else begin
			// next status against next mask: a masked event never shows
			IRQ <= |((irq_evt |
				(irq_status & ~(wr_sts ? PWDATA[2*NUM_CH-1:0] : '0))) &
				(wr_msk ? PWDATA[2*NUM_CH-1:0] : irq_mask));
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	// captured at setup so the access edge returns pre-read contents
	always_comb begin
		next_prdata = 32'h0000_0000;
		for (int i = 0; i < NUM_CH; i++) begin
			if (hit_ch[i]) begin
				next_prdata[acrr_pkg::POS_OVERRUN] = overwrite_flag[i];
				next_prdata[acrr_pkg::POS_FRESH]   = fresh_flag[i];
				next_prdata[acrr_pkg::POS_HOLD]    = hold_until_read[i];
				next_prdata[11:0]                  = sample_value[i];
			end
		end
		if (hit_sts) begin
			next_prdata[2*NUM_CH-1:0] = irq_status;
		end
		if (hit_msk) begin
			next_prdata[2*NUM_CH-1:0] = irq_mask;
		end
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
			PREADY  <= 1'b0;
		end else begin
			PREADY <= setup;
			if (setup) begin
				PRDATA  <= PWRITE ? 32'h0000_0000 : next_prdata;
				PSLVERR <= !(|hit_ch || hit_sts || hit_msk);
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_read_clears;
		@(posedge REF_CLK) disable iff (!RESET_CLASS3_B)
		rd_ch[0] && !take[0] |=> !fresh_flag[0] && !overwrite_flag[0];
	endproperty
	a_read_clears: assert property (p_read_clears)
		else $error("read did not clear flags");

	property p_overrun;
		@(posedge REF_CLK) disable iff (!RESET_CLASS3_B)
		SAMPLE_CH3.valid && fresh_flag[0] && !hold_until_read[0] &&
			!SOFTWARE_MODE && !rd_ch[0] |=> overwrite_flag[0];
	endproperty
	a_overrun: assert property (p_overrun)
		else $error("overrun not flagged");

	property p_no_ovr_hold;
		@(posedge REF_CLK) disable iff (!RESET_CLASS3_B)
		!overwrite_flag[1] && (hold_until_read[1] || SOFTWARE_MODE)
			|=> !overwrite_flag[1];
	endproperty
	a_no_ovr_hold: assert property (p_no_ovr_hold)
		else $error("overrun set while forbidden");

	property p_fresh_set;
		@(posedge REF_CLK) disable iff (!RESET_CLASS3_B)
		SAMPLE_CH4.valid && !fresh_flag[1] |=> fresh_flag[1];
	endproperty
	a_fresh_set: assert property (p_fresh_set)
		else $error("fresh flag not set");

	property p_hold;
		@(posedge REF_CLK) disable iff (!RESET_CLASS3_B)
		hold_until_read[0] && fresh_flag[0] |=> $stable(sample_value[0]);
	endproperty
	a_hold: assert property (p_hold)
		else $error("pending result overwritten");

	property p_pad8;
		@(posedge REF_CLK) disable iff (!RESET_CLASS3_B)
		take[0] && SAMPLE_CH3.width == acrr_pkg::ACRR_RES_8
			|=> sample_value[0] == {$past(SAMPLE_CH3.raw[7:0]), 4'h0};
	endproperty
	a_pad8: assert property (p_pad8)
		else $error("8-bit placement wrong");

	property p_pad10;
		@(posedge REF_CLK) disable iff (!RESET_CLASS3_B)
		take[1] && SAMPLE_CH4.width == acrr_pkg::ACRR_RES_10
			|=> sample_value[1] == {$past(SAMPLE_CH4.raw), 2'h0};
	endproperty
	a_pad10: assert property (p_pad10)
		else $error("10-bit placement wrong");

	property p_reserved;
		@(posedge REF_CLK) disable iff (!RST_B)
		PREADY |-> PRDATA[31:19] == 13'h0 && PRDATA[15:12] == 4'h0;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved bits not zero");

	property p_mode_write;
		@(posedge REF_CLK) disable iff (!RESET_CLASS3_B)
		wr_ch[1] |=> hold_until_read[1] == $past(PWDATA[acrr_pkg::POS_HOLD]);
	endproperty
	a_mode_write: assert property (p_mode_write)
		else $error("mode bit not written");

	property p_light_reset;
		@(posedge REF_CLK) disable iff (!RESET_CLASS3_B)
		$fell(RST_B) && $past(take) == '0 && $past(rd_ch) == '0 &&
			$past(wr_ch) == '0
			|-> $stable({fresh_flag, overwrite_flag, hold_until_read});
	endproperty
	a_light_reset: assert property (p_light_reset)
		else $error("light reset touched result flags");

endmodule : acrr_bank

// >>> dv/acrr_seq_model.sv
// behavioural converter sequencer handing results to the bank
// assumes the bank samples results on the rising edge of clk
`timescale 1ns/1ps
module acrr_seq_model (
	input  wire logic                 clk,
	output acrr_pkg::acrr_sample_type ch3,
	output acrr_pkg::acrr_sample_type ch4
);
	// idle lines start quiet before the first result
	initial begin
		ch3 = '0;
		ch4 = '0;
	end

	// one-cycle result pulse; raw is inverted afterwards so that a bank
	// sampling outside the pulse never sees a stable stale value
	task automatic put(input logic c4, input logic w10, input logic [9:0] r);
		acrr_pkg::acrr_width_type w;
		w = w10 ? acrr_pkg::ACRR_RES_10 : acrr_pkg::ACRR_RES_8;
		@(posedge clk);
		if (c4)
			ch4 <= {1'b1, w, r};
		else
			ch3 <= {1'b1, w, r};
		@(posedge clk);
		ch3 <= {1'b0, ch3.width, ~ch3.raw};
		ch4 <= {1'b0, ch4.width, ~ch4.raw};
	endtask : put
endmodule : acrr_seq_model

// >>> dv/acrr_bank_tb.sv
// self-checking bench for the conversion result register bank
// assumes acrr_seq_model as the sequencer and a 50 MHz reference clock
`timescale 1ns/1ps
module acrr_bank_tb;
	localparam logic [11:0] A3 = acrr_pkg::OFS_RESULT_CH3;
	localparam logic [11:0] A4 = acrr_pkg::OFS_RESULT_CH4;
	localparam logic [11:0] AS = acrr_pkg::OFS_IRQ_STATUS;
	localparam logic [11:0] AM = acrr_pkg::OFS_IRQ_MASK;
	logic                      ref_clk = 1'b0;
	logic                      rst_b = 1'b0;
	logic                      rst3_b = 1'b0;
	logic                      psel = 1'b0;
	logic                      penable = 1'b0;
	logic                      pwrite = 1'b0;
	logic                      sw_mode = 1'b0;
	logic [11:0]               paddr = '0;
	logic [31:0]               pwdata = '0;
	logic [31:0]               prdata;
	logic [31:0]               rd;
	logic                      pready;
	logic                      pslverr;
	logic                      irq;
	logic                      err;
	acrr_pkg::acrr_sample_type s3;
	acrr_pkg::acrr_sample_type s4;
	int                        err_count = 0;
	int                        samples_checked = 0;

	// 20 ns period
	always #10 ref_clk = ~ref_clk;

	acrr_seq_model seq_i (.clk(ref_clk), .ch3(s3), .ch4(s4));
	acrr_bank #(.NUM_CH(2)) acrr_bank_i (.REF_CLK(ref_clk), .RST_B(rst_b),
		.RESET_CLASS3_B(rst3_b), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.SAMPLE_CH3(s3), .SAMPLE_CH4(s4), .SOFTWARE_MODE(sw_mode),
		.IRQ(irq));

	// ----------------------------------------------------------------
	// shared helpers
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// one apb transfer; no wait count of its own, a stuck slave is left
	// to the watchdog
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// request stands until pready is seen high at a rising edge
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, '0);
		chk("read word", rd, exp);
	endtask : rdc

	// expected register image from flags and a raw result
	function automatic logic [31:0] word(input logic ov, fr, hd, w10,
		input logic [9:0] r);
		word = {13'h0, ov, fr, hd, 4'h0, w10 ? {r, 2'h0} : {r[7:0], 4'h0}};
	endfunction : word

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_basic;
		rdc(A3, 32'h0);
		rdc(AM, 32'h0);
		seq_i.put(1'b0, 1'b1, 10'h2a5);
		rdc(A3, word(0, 1, 0, 1, 10'h2a5));
		rdc(A3, word(0, 0, 0, 1, 10'h2a5));
		seq_i.put(1'b1, 1'b0, 10'h3c7);
		rdc(A4, word(0, 1, 0, 0, 10'h3c7));
		$display("test basic done");
	endtask : t_basic

	// unread result overwritten once, then again with software mode raised
	task automatic t_overrun;
		seq_i.put(1'b0, 1'b1, 10'h111);
		seq_i.put(1'b0, 1'b1, 10'h222);
		rdc(A3, word(1, 1, 0, 1, 10'h222));
		rdc(A3, word(0, 0, 0, 1, 10'h222));
		@(posedge ref_clk);
		sw_mode <= 1'b1;
		seq_i.put(1'b0, 1'b1, 10'h0f0);
		seq_i.put(1'b0, 1'b1, 10'h30f);
		rdc(A3, word(0, 1, 0, 1, 10'h30f));
		sw_mode <= 1'b0;
		$display("test overrun done");
	endtask : t_overrun

	// all ones written: only the mode bit may stick
	task automatic t_hold;
		apb(1'b1, A4, 32'hffff_ffff);
		rdc(A4, word(0, 0, 1, 0, 10'h3c7));
		seq_i.put(1'b1, 1'b0, 10'h0a5);
		seq_i.put(1'b1, 1'b0, 10'h05a);
		rdc(A4, word(0, 1, 1, 0, 10'h0a5));
		seq_i.put(1'b1, 1'b0, 10'h05a);
		rdc(A4, word(0, 1, 1, 0, 10'h05a));
		// channel three in hold mode: 8-bit result kept, next one dropped
		apb(1'b1, A3, 32'h0001_0000);
		seq_i.put(1'b0, 1'b0, 10'h0c3);
		seq_i.put(1'b0, 1'b1, 10'h13c);
		rdc(A3, word(0, 1, 1, 0, 10'h0c3));
		$display("test hold done");
	endtask : t_hold

	// light reset keeps results, heavy reset clears them
	task automatic t_reset;
		@(posedge ref_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		rdc(A4, word(0, 0, 1, 0, 10'h05a));
		rst3_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst3_b <= 1'b1;
		rdc(A4, 32'h0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_irq;
		apb(1'b1, AM, 32'h1);
		seq_i.put(1'b0, 1'b1, 10'h001);
		@(negedge ref_clk);
		chk("irq raised", {31'h0, irq}, 32'h1);
		rdc(AS, 32'h1);
		apb(1'b1, AS, 32'h1);
		seq_i.put(1'b1, 1'b1, 10'h002);
		@(negedge ref_clk);
		chk("irq masked", {31'h0, irq}, 32'h0);
		rdc(AS, 32'h4);
		rdc(12'h200, 32'h0);
		chk("slave error", {31'h0, err}, 32'h1);
		$display("test irq done");
	endtask : t_irq

	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test

	// watchdog: the whole run needs a few hundred cycles at most
	initial begin
		repeat (2000) @(posedge ref_clk);
		err_count++;
		finish_test();
	end

	initial begin
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		rst3_b <= 1'b1;
		t_basic();
		t_overrun();
		t_hold();
		t_reset();
		t_irq();
		finish_test();
	end
endmodule : acrr_bank_tb
